// file: core_side.sv
// Core and peripheral side model: sleep requests, short offsets, tick counts
`timescale 1ns/1ps
module core_side (
   input  wire        mclk,
   input  wire        core_rst_b,
   input  wire        core_clk_en,
   input  wire        periph_clk_en,
   input  wire [1:0]  sleep_cmd,
   output reg         wait_req = 1'b0,
   output reg         stop_req = 1'b0,
   output reg  [5:0]  io_short_off = 6'h00,
   output reg  [31:0] core_ticks = 32'h0,
   output reg  [31:0] periph_ticks = 32'h0
);
   always @(posedge mclk) begin
      wait_req <= sleep_cmd[0];
      stop_req <= sleep_cmd[1];
      core_ticks <= core_ticks + {31'h0, core_clk_en};
      periph_ticks <= periph_ticks + {31'h0, periph_clk_en};
      if (!core_rst_b)
         io_short_off <= 6'h00;
      else if (core_clk_en)
         io_short_off <= io_short_off + 6'h01;
   end
endmodule

// file: reset_sequencer.v
// Reset release sequencer: stretch, clock start, peripheral release, core init
`timescale 1ns/1ps
`include "sys_ctrl_consts.vh"
module reset_sequencer #(
   parameter STRETCH = `POR_STRETCH_CYCLES,
   parameter WINDOW  = `RESET_WINDOW_CYCLES
) (
   input  wire        mclk,
   input  wire        por_b,
   input  wire        ext_b,
   input  wire        sync_rst,
   input  wire        tick,
   output reg         clocks_run_r,
   output reg         periph_rst_b_r,
   output reg         core_rst_b_r,
   output reg  [4:0]  stage_r
);
   localparam S_STRETCH = 5'b00001;
   localparam S_CLKS    = 5'b00010;
   localparam S_PERIPH  = 5'b00100;
   localparam S_CORE    = 5'b01000;
   localparam S_DONE    = 5'b10000;

   reg [21:0] cnt_r;
   reg [4:0]  state_nxt;
   reg [21:0] cnt_nxt;
   wire       win_end;
   wire       str_end;

   assign win_end = (cnt_r == WINDOW[21:0] - 22'h000001);
   assign str_end = (cnt_r == STRETCH[21:0] - 22'h000001);

   always @* begin
      state_nxt = stage_r;
      cnt_nxt   = cnt_r;
      if (tick) begin
         cnt_nxt = cnt_r + 22'h000001;
         case (stage_r)
            S_STRETCH: if (str_end) begin
               state_nxt = S_CLKS;
               cnt_nxt   = 22'h000000;
            end
            S_CLKS: if (win_end) begin
               state_nxt = S_PERIPH;
               cnt_nxt   = 22'h000000;
            end
            S_PERIPH: if (win_end) begin
               state_nxt = S_CORE;
               cnt_nxt   = 22'h000000;
            end
            S_CORE: if (win_end) begin
               state_nxt = S_DONE;
               cnt_nxt   = 22'h000000;
            end
            S_DONE: cnt_nxt = 22'h000000;
            default: begin
               state_nxt = S_STRETCH;
               cnt_nxt   = 22'h000000;
            end
         endcase
      end
      if (sync_rst || !ext_b) begin
         state_nxt = S_CLKS;
         cnt_nxt   = 22'h000000;
      end
   end

   // release only on system clock edge
   always @(posedge mclk or negedge por_b) begin
      if (!por_b) begin
         stage_r        <= S_STRETCH;
         cnt_r          <= 22'h000000;
         clocks_run_r   <= 1'b0;
         periph_rst_b_r <= 1'b0;
         core_rst_b_r   <= 1'b0;
      end else begin
         stage_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         if (sync_rst || !ext_b) begin
            clocks_run_r   <= 1'b0;
            periph_rst_b_r <= 1'b0;
            core_rst_b_r   <= 1'b0;
         end else if (tick) begin
            clocks_run_r   <= (state_nxt != S_STRETCH);
            periph_rst_b_r <= (state_nxt == S_CORE) || (state_nxt == S_DONE);
            core_rst_b_r   <= (state_nxt == S_DONE);
         end
      end
   end
endmodule

// file: sys_ctrl.v
// System clock, power mode, short-address base and reset control block
//
// Operation
// - Four gate bits enable peripheral clocks
// - Short address: six instruction bits plus base
// - High base holds bits 23:22, rest ones
// - Low base holds address bits 21:6
// - Base pair resets to top of memory
// - Off-top base with external mode blocks debug
// - New base used four cycles after write
// - System clocks at half master rate
// - Wait stops core, interrupt resumes
// - Stop gates clocks, limited wake sources
// - Peripherals run from peripheral bus clock
// - Stop/wait disable, temporary or permanent until reset
// - Four reset sources, two async two sync
// - POR stretched then three 32-clock windows
// - Reset released on system clock edge
`timescale 1ns/1ps
`include "sys_ctrl_consts.vh"
module sys_ctrl #(
   parameter POR_STRETCH = `POR_STRETCH_CYCLES
) (
   input  wire        mclk,
   input  wire        rst_b,
   input  wire        ext_rst_b,
   input  wire        watchdog_rst,
   input  wire [5:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   input  wire        stop_req,
   input  wire        wait_req,
   input  wire        periph_irq,
   input  wire        can_wake,
   input  wire        async_irq,
   input  wire        external_memory_select,
   input  wire [5:0]  io_short_off,
   output reg  [23:0] io_short_addr,
   output reg         debug_block,
   output reg         system_clock_en,
   output reg         core_clk_en,
   output reg         periph_clk_en,
   output reg         serial_port_one_clk_en,
   output reg         serial_port_zero_clk_en,
   output reg         pulse_mod_b_clk_en,
   output reg         pulse_mod_a_clk_en,
   output reg         core_rst_b,
   output reg         periph_rst_b
);
   localparam P_RUN  = 3'b001;
   localparam P_WAIT = 3'b010;
   localparam P_STOP = 3'b100;

   reg         por_meta_r;
   reg         por_sync_r;
   reg         ext_meta_r;
   reg         ext_sync_r;
   reg         div_r;
   reg         sw_rst_r;
   reg  [15:0] pce_r;
   reg  [1:0]  base_high_r;
   reg  [15:0] base_low_r;
   reg  [4:0]  ctl_r;
   reg  [2:0]  pmode_r;
   reg  [2:0]  pmode_nxt;
   reg  [17:0] base_pipe_r [0:`BASE_PIPE_CYCLES-1];
   reg  [15:0] rd_nxt;
   wire        tick;
   wire        clocks_run;
   wire        seq_periph_b;
   wire        seq_core_b;
   wire [4:0]  seq_stage;
   wire [3:0]  idx;
   wire        req;
   wire        wr_take;
   wire        wait_dis;
   wire        stop_dis;
   wire [17:0] base_eff;
   wire        periph_on;
   wire        core_on;

   function automatic hit;
      input [5:0] a;
      input [3:0] i;
      begin
         hit = (a[5:2] == i) && (a[1:0] == 2'h0);
      end
   endfunction

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         por_meta_r <= 1'b0;
         por_sync_r <= 1'b0;
      end else begin
         por_meta_r <= 1'b1;
         por_sync_r <= por_meta_r;
      end
   end

   always @(posedge mclk or negedge ext_rst_b) begin
      if (!ext_rst_b) begin
         ext_meta_r <= 1'b0;
         ext_sync_r <= 1'b0;
      end else begin
         ext_meta_r <= 1'b1;
         ext_sync_r <= ext_meta_r;
      end
   end

   always @(posedge mclk or negedge por_sync_r) begin
      if (!por_sync_r)
         div_r <= 1'b0;
      else
         div_r <= ~div_r;
   end
   assign tick = div_r;

   reset_sequencer #(
      .STRETCH (POR_STRETCH),
      .WINDOW  (`RESET_WINDOW_CYCLES)
   ) u_seq (
      .mclk           (mclk),
      .por_b          (por_sync_r),
      .ext_b          (ext_sync_r),
      .sync_rst       (sw_rst_r | watchdog_rst),
      .tick           (tick),
      .clocks_run_r   (clocks_run),
      .periph_rst_b_r (seq_periph_b),
      .core_rst_b_r   (seq_core_b),
      .stage_r        (seq_stage)
   );

   assign idx     = avs_address[5:2];
   assign req     = avs_read | avs_write;
   assign wr_take = avs_write & ~avs_waitrequest;

   // Bus answer: one wait cycle per access
   always @(posedge mclk or negedge por_sync_r) begin
      if (!por_sync_r)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= ~(req & avs_waitrequest);
   end

   always @* begin
      rd_nxt = 16'h0000;
      if (hit(avs_address, `IDX_SYS_CONTROL))
         rd_nxt = {11'h000, ctl_r};
      else if (hit(avs_address, `IDX_SYS_STATUS))
         rd_nxt = {5'h00, seq_stage, clocks_run, pmode_r, stop_dis, wait_dis};
      else if (hit(avs_address, `IDX_PCE))
         rd_nxt = pce_r;
      else if (hit(avs_address, `IDX_BASE_HIGH))
         rd_nxt = {`BASE_HIGH_ONES, base_high_r};
      else if (hit(avs_address, `IDX_BASE_LOW))
         rd_nxt = base_low_r;
   end

   always @(posedge mclk or negedge por_sync_r) begin
      if (!por_sync_r)
         avs_readdata <= 32'h00000000;
      else if (avs_read & avs_waitrequest)
         avs_readdata <= {16'h0000, rd_nxt};
   end

   // Registers cleared by any reset while core held
   always @(posedge mclk or negedge por_sync_r) begin
      if (!por_sync_r) begin
         pce_r       <= `RST_PCE;
         base_high_r <= `RST_BASE_HIGH;
         base_low_r  <= `RST_BASE_LOW;
         ctl_r       <= `RST_CONTROL;
         sw_rst_r    <= 1'b0;
      end else if (!seq_core_b) begin
         // base pair back to top of memory
         pce_r       <= `RST_PCE;
         base_high_r <= `RST_BASE_HIGH;
         base_low_r  <= `RST_BASE_LOW;
         ctl_r       <= `RST_CONTROL;
         sw_rst_r    <= 1'b0;
      end else begin
         sw_rst_r <= wr_take && hit(avs_address, `IDX_SYS_CONTROL)
                     && avs_writedata[`CTL_SW_RESET];
         if (wr_take && hit(avs_address, `IDX_SYS_CONTROL)) begin
            ctl_r[`CTL_WAIT_DIS_TEMP] <= avs_writedata[`CTL_WAIT_DIS_TEMP];
            ctl_r[`CTL_STOP_DIS_TEMP] <= avs_writedata[`CTL_STOP_DIS_TEMP];
            ctl_r[`CTL_WAIT_DIS_PERM] <= ctl_r[`CTL_WAIT_DIS_PERM]
                                         | avs_writedata[`CTL_WAIT_DIS_PERM];
            ctl_r[`CTL_STOP_DIS_PERM] <= ctl_r[`CTL_STOP_DIS_PERM]
                                         | avs_writedata[`CTL_STOP_DIS_PERM];
         end
         if (wr_take && hit(avs_address, `IDX_PCE))
            pce_r <= avs_writedata[15:0];
         if (wr_take && hit(avs_address, `IDX_BASE_HIGH))
            base_high_r <= avs_writedata[1:0];
         if (wr_take && hit(avs_address, `IDX_BASE_LOW))
            base_low_r <= avs_writedata[15:0];
      end
   end

   genvar g;
   generate
      for (g = 0; g < `BASE_PIPE_CYCLES; g = g + 1) begin : g_pipe
         wire [17:0] src;
         // First stage takes the registers, later stages the stage before
         if (g == 0) begin : g_first
            assign src = {base_high_r, base_low_r};
         end else begin : g_next
            assign src = base_pipe_r[g-1];
         end
         always @(posedge mclk or negedge por_sync_r) begin
            if (!por_sync_r)
               base_pipe_r[g] <= `BASE_TOP_OF_MEM;
            else
               base_pipe_r[g] <= src;
         end
      end
   endgenerate
   assign base_eff = base_pipe_r[`BASE_PIPE_CYCLES-1];

   always @(posedge mclk or negedge por_sync_r) begin
      if (!por_sync_r) begin
         io_short_addr <= {`BASE_TOP_OF_MEM, 6'h00};
         debug_block   <= 1'b0;
      end else begin
         io_short_addr <= {base_eff, io_short_off};
         debug_block   <= (base_eff != `BASE_TOP_OF_MEM) & external_memory_select;
      end
   end

   assign wait_dis = ctl_r[`CTL_WAIT_DIS_TEMP] | ctl_r[`CTL_WAIT_DIS_PERM];
   assign stop_dis = ctl_r[`CTL_STOP_DIS_TEMP] | ctl_r[`CTL_STOP_DIS_PERM];

   always @* begin
      pmode_nxt = pmode_r;
      case (pmode_r)
         P_RUN: begin
            if (stop_req && !stop_dis)
               pmode_nxt = P_STOP;
            else if (wait_req && !wait_dis)
               pmode_nxt = P_WAIT;
         end
         P_WAIT: if (periph_irq)
            pmode_nxt = P_RUN;
         P_STOP: if (can_wake || async_irq)
            pmode_nxt = P_RUN;
         default: pmode_nxt = P_RUN;
      endcase
   end

   always @(posedge mclk or negedge por_sync_r) begin
      if (!por_sync_r)
         pmode_r <= P_RUN;
      else if (!seq_core_b)
         pmode_r <= P_RUN;
      else
         pmode_r <= pmode_nxt;
   end

   assign core_on   = clocks_run & (pmode_r == P_RUN);
   assign periph_on = clocks_run & (pmode_r != P_STOP);

   always @(posedge mclk or negedge por_sync_r) begin
      if (!por_sync_r) begin
         system_clock_en              <= 1'b0;
         core_clk_en             <= 1'b0;
         periph_clk_en           <= 1'b0;
         serial_port_one_clk_en  <= 1'b0;
         serial_port_zero_clk_en <= 1'b0;
         pulse_mod_b_clk_en      <= 1'b0;
         pulse_mod_a_clk_en      <= 1'b0;
         core_rst_b              <= 1'b0;
         periph_rst_b            <= 1'b0;
      end else begin
         system_clock_en              <= ~div_r;
         core_clk_en             <= ~div_r & core_on;
         periph_clk_en           <= ~div_r & periph_on;
         serial_port_one_clk_en  <= ~div_r & periph_on & pce_r[`PCE_SERIAL_ONE];
         serial_port_zero_clk_en <= ~div_r & periph_on & pce_r[`PCE_SERIAL_ZERO];
         pulse_mod_b_clk_en      <= ~div_r & periph_on & pce_r[`PCE_PULSE_MOD_B];
         pulse_mod_a_clk_en      <= ~div_r & periph_on & pce_r[`PCE_PULSE_MOD_A];
         core_rst_b              <= seq_core_b;
         periph_rst_b            <= seq_periph_b;
      end
   end
endmodule

// file: sys_ctrl_bench.sv
// Self-checking bench for the system control block
`timescale 1ns/1ps
module sys_ctrl_bench;
   reg         mclk = 1'b0;
   reg         rst_b = 1'b0;
   reg         ext_rst_b = 1'b1;
   reg         watchdog_rst = 1'b0;
   reg  [5:0]  avs_address = 6'h00;
   reg         avs_read = 1'b0;
   reg         avs_write = 1'b0;
   reg  [31:0] avs_writedata = 32'h0;
   reg         periph_irq = 1'b0;
   reg         can_wake = 1'b0;
   reg         async_irq = 1'b0;
   reg         ext_mem = 1'b1;
   reg  [1:0]  sleep_cmd = 2'h0;
   wire [31:0] avs_readdata;
   wire [31:0] core_ticks;
   wire [31:0] periph_ticks;
   wire [23:0] io_short_addr;
   wire [5:0]  io_short_off;
   wire [3:0]  gate_en;
   wire        avs_waitrequest, stop_req, wait_req, debug_block, system_clock_en, core_clk_en;
   wire        periph_clk_en, core_rst_b, periph_rst_b;
   integer     n_mismatch = 0;
   integer     comparisons = 0;
   integer     n;
   reg  [31:0] q;
   always #2 mclk = ~mclk;
   sys_ctrl #(.POR_STRETCH(8)) DUT (.mclk(mclk), .rst_b(rst_b), .ext_rst_b(ext_rst_b),
      .watchdog_rst(watchdog_rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .stop_req(stop_req), .wait_req(wait_req),
      .periph_irq(periph_irq), .can_wake(can_wake), .async_irq(async_irq),
      .external_memory_select(ext_mem), .io_short_off(io_short_off),
      .io_short_addr(io_short_addr), .debug_block(debug_block), .system_clock_en(system_clock_en),
      .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
      .serial_port_one_clk_en(gate_en[3]), .serial_port_zero_clk_en(gate_en[2]),
      .pulse_mod_b_clk_en(gate_en[1]), .pulse_mod_a_clk_en(gate_en[0]),
      .core_rst_b(core_rst_b), .periph_rst_b(periph_rst_b));
   core_side partner (.mclk(mclk), .core_rst_b(core_rst_b), .core_clk_en(core_clk_en),
      .periph_clk_en(periph_clk_en), .sleep_cmd(sleep_cmd), .wait_req(wait_req),
      .stop_req(stop_req), .io_short_off(io_short_off), .core_ticks(core_ticks),
      .periph_ticks(periph_ticks));
   task results;
      begin
         if (n_mismatch == 0 && comparisons > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task check(input [31:0] got, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task give_up;
      begin
         n_mismatch = n_mismatch + 1;
         results;
      end
   endtask
   // Avalon access: hold until waitrequest sampled low
   task bus(input wr, input [5:0] a, input [15:0] d);
      integer k;
      begin
         k = 0;
         @(posedge mclk);
         avs_address <= a;
         avs_writedata <= {16'h0, d};
         avs_read <= !wr;
         avs_write <= wr;
         @(posedge mclk);
         while (avs_waitrequest !== 1'b0 && k < 50) begin
            @(posedge mclk);
            k = k + 1;
         end
         if (k == 50)
            give_up;
         q = avs_readdata;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
      end
   endtask
   task rd(input [5:0] a, input [31:0] exp);
      begin
         bus(1'b0, a, 16'h0000);
         check(q, exp);
      end
   endtask
   task wait_core(output integer c);
      begin
         c = 0;
         while (core_rst_b !== 1'b1 && c < 3000) begin
            @(posedge mclk);
            c = c + 1;
         end
         if (c == 3000)
            give_up;
      end
   endtask
   task power_chk(input [31:0] ec, input [31:0] ep);
      reg [31:0] c0, p0;
      begin
         c0 = core_ticks;
         p0 = periph_ticks;
         repeat (20) @(posedge mclk);
         check(core_ticks - c0, ec);
         check(periph_ticks - p0, ep);
      end
   endtask
   task sleep(input [1:0] c);
      begin
         sleep_cmd <= c;
         @(posedge mclk);
         sleep_cmd <= 2'h0;
         repeat (4) @(posedge mclk);
      end
   endtask
   task t_regs;
      begin
         rd(6'h30, 32'hFFFF);
         rd(6'h34, 32'hFFFF);
         rd(6'h38, 32'hFFFF);
         rd(6'h04, 32'h424);
         bus(1'b1, 6'h3C, 16'h5A5A);
         rd(6'h3C, 32'h0);
         check({14'h0, io_short_addr[23:6]}, 32'h3FFFF);
         check({31'h0, debug_block}, 32'h0);
      end
   endtask
   task t_gates;
      integer i, k;
      integer cnt [0:3];
      begin
         for (i = 0; i < 4; i = i + 1) begin
            bus(1'b1, 6'h30, 16'h0001 << i);
            rd(6'h30, 32'h0001 << i);
            for (k = 0; k < 4; k = k + 1)
               cnt[k] = 0;
            repeat (32) begin
               @(negedge mclk);
               for (k = 0; k < 4; k = k + 1)
                  cnt[k] = cnt[k] + gate_en[k];
            end
            for (k = 0; k < 4; k = k + 1)
               check(cnt[k], (k == i) ? 32'h10 : 32'h0);
         end
         bus(1'b1, 6'h30, 16'hFFFF);
      end
   endtask
   task t_base;
      integer k;
      begin
         bus(1'b1, 6'h34, 16'h0002);
         rd(6'h34, 32'hFFFE);
         bus(1'b1, 6'h38, 16'h1234);
         for (k = 0; k < 5; k = k + 1) begin
            @(negedge mclk);
            check({14'h0, io_short_addr[23:6]}, (k < 4) ? 32'h2FFFF : 32'h21234);
            @(posedge mclk);
         end
         rd(6'h38, 32'h1234);
         check({31'h0, debug_block}, 32'h1);
         ext_mem <= 1'b0;
         repeat (3) @(posedge mclk);
         check({31'h0, debug_block}, 32'h0);
         ext_mem <= 1'b1;
         bus(1'b1, 6'h34, 16'h0003);
         bus(1'b1, 6'h38, 16'hFFFF);
         repeat (5) @(posedge mclk);
         check({14'h0, io_short_addr[23:6]}, 32'h3FFFF);
      end
   endtask
   task t_power;
      integer w;
      begin
         power_chk(32'hA, 32'hA);
         sleep(2'h1);
         power_chk(32'h0, 32'hA);
         periph_irq <= 1'b1;
         repeat (4) @(posedge mclk);
         periph_irq <= 1'b0;
         power_chk(32'hA, 32'hA);
         for (w = 0; w < 2; w = w + 1) begin
            sleep(2'h2);
            power_chk(32'h0, 32'h0);
            can_wake <= (w == 0);
            async_irq <= (w == 1);
            repeat (4) @(posedge mclk);
            can_wake <= 1'b0;
            async_irq <= 1'b0;
            power_chk(32'hA, 32'hA);
         end
         bus(1'b1, 6'h00, 16'h0002);
         sleep(2'h1);
         power_chk(32'hA, 32'hA);
         bus(1'b1, 6'h00, 16'h0010);
         bus(1'b1, 6'h00, 16'h0000);
         rd(6'h00, 32'h10);
         sleep(2'h2);
         power_chk(32'hA, 32'hA);
         bus(1'b1, 6'h00, 16'h000C);
         rd(6'h00, 32'h1C);
         sleep(2'h1);
         power_chk(32'hA, 32'hA);
      end
   endtask
   task t_resets;
      integer s;
      begin
         for (s = 0; s < 3; s = s + 1) begin
            bus(1'b1, 6'h30, 16'h0000);
            watchdog_rst <= (s == 0);
            ext_rst_b <= (s != 1);
            if (s == 2)
               bus(1'b1, 6'h00, 16'h0001);
            repeat (4) @(posedge mclk);
            watchdog_rst <= 1'b0;
            ext_rst_b <= 1'b1;
            check({30'h0, core_rst_b, periph_rst_b}, 32'h0);
            wait_core(n);
            check({31'h0, n >= 180 && n <= 200}, 32'h1);
            rd(6'h00, 32'h0);
            rd(6'h30, 32'hFFFF);
         end
      end
   endtask
   initial begin
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      wait_core(n);
      check({31'h0, n >= 208 && n <= 216}, 32'h1);
      check({31'h0, periph_rst_b}, 32'h1);
      t_regs;
      t_gates;
      t_base;
      t_power;
      t_resets;
      results;
   end
endmodule

// file: sys_ctrl_checker.sv
// Port-level assertions for the system control block
`timescale 1ns/1ps
module sys_ctrl_checker #(
   parameter POR_STRETCH = 8
) (
   input wire        mclk,
   input wire        rst_b,
   input wire        avs_read,
   input wire        avs_write,
   input wire        avs_waitrequest,
   input wire        external_memory_select,
   input wire [5:0]  io_short_off,
   input wire [23:0] io_short_addr,
   input wire        debug_block,
   input wire        system_clock_en,
   input wire        core_clk_en,
   input wire        periph_clk_en,
   input wire        serial_port_one_clk_en,
   input wire        serial_port_zero_clk_en,
   input wire        pulse_mod_b_clk_en,
   input wire        pulse_mod_a_clk_en,
   input wire        core_rst_b,
   input wire        periph_rst_b
);
   wire gates;
   assign gates = serial_port_one_clk_en | serial_port_zero_clk_en | pulse_mod_b_clk_en
                  | pulse_mod_a_clk_en;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   gate_sub_a: assert property (gates |-> periph_clk_en)
      else $error("gate pulse without peripheral clock");
   half_rate_a: assert property (system_clock_en |=> !system_clock_en ##1 system_clock_en)
      else $error("system clock enable not at half rate");
   core_run_a: assert property (core_clk_en |-> periph_clk_en && system_clock_en)
      else $error("core clock without peripheral clock");
   periph_sub_a: assert property (periph_clk_en |-> system_clock_en)
      else $error("peripheral clock off system rate");
   debug_cut_a: assert property (debug_block == (io_short_addr[23:6] != 18'h3FFFF
      && $past(external_memory_select))) else $error("debug block wrong");
   short_off_a: assert property (core_rst_b && $past(core_rst_b)
      |-> io_short_addr[5:0] == $past(io_short_off)) else $error("short offset lost");
   rst_order_a: assert property (core_rst_b |-> periph_rst_b)
      else $error("core released before peripherals");
   rst_gap_a: assert property ($rose(periph_rst_b) |-> !core_rst_b [*8])
      else $error("core window too short");
   bus_answer_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
      else $error("bus answer late");
   wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
endmodule

bind sys_ctrl sys_ctrl_checker #(.POR_STRETCH(POR_STRETCH)) chk (.mclk(mclk), .rst_b(rst_b),
   .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
   .external_memory_select(external_memory_select), .io_short_off(io_short_off),
   .io_short_addr(io_short_addr), .debug_block(debug_block), .system_clock_en(system_clock_en),
   .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
   .serial_port_one_clk_en(serial_port_one_clk_en),
   .serial_port_zero_clk_en(serial_port_zero_clk_en),
   .pulse_mod_b_clk_en(pulse_mod_b_clk_en), .pulse_mod_a_clk_en(pulse_mod_a_clk_en),
   .core_rst_b(core_rst_b), .periph_rst_b(periph_rst_b));

// file: sys_ctrl_consts.vh
// Register map, reset values and timing counts of the system control block
`ifndef SYS_CTRL_CONSTS_VH
`define SYS_CTRL_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_SYS_CONTROL      4'h0
`define IDX_SYS_STATUS       4'h1
`define IDX_PCE              4'hC
`define IDX_BASE_HIGH        4'hD
`define IDX_BASE_LOW         4'hE

// System control register fields
`define CTL_SW_RESET         0
`define CTL_WAIT_DIS_TEMP    1
`define CTL_STOP_DIS_TEMP    2
`define CTL_WAIT_DIS_PERM    3
`define CTL_STOP_DIS_PERM    4

// Peripheral clock gate fields
`define PCE_PULSE_MOD_A      0
`define PCE_PULSE_MOD_B      1
`define PCE_SERIAL_ZERO      2
`define PCE_SERIAL_ONE       3

// Reset values
`define RST_PCE              16'hFFFF
`define RST_BASE_HIGH        2'h3
`define RST_BASE_LOW         16'hFFFF
`define RST_CONTROL          5'h00
`define BASE_HIGH_ONES       14'h3FFF
`define BASE_TOP_OF_MEM      18'h3FFFF

// Timing: master clock 250 MHz in simulation, limit 120 MHz in silicon
`define MCLK_MHZ             250
`define MCLK_MAX_MHZ         120
`define SYSTEM_CLOCK_DIV          2
`define POR_STRETCH_CYCLES   2097152
`define RESET_WINDOW_CYCLES  32
`define BASE_PIPE_CYCLES     3

`endif
